// >>> src/rtcp_host_port.sv
// Purpose: Host port and user data space of a low-power real-time clock.
// Assumes: Pins are synchronised into mclk by three flip-flops each.
// Notes: Live time and timer values arrive from and leave to the keeping logic as flat buses.
//
// Overview of operation
// RULE_01: Power fail low puts the device into standby.
// RULE_02: In standby inputs are ignored and all bus lines released.
// RULE_03: Host keeps all inputs at defined levels when power fail releases.
// RULE_04: Power fail may be driven from the system reset.
// RULE_05: Unmasked alarm pulls interrupt line low even in standby.
// RULE_06: Registers have no guaranteed reset value.
// RULE_07: Software initialises by writing one then zero to status 2 bit 4.
// RULE_08: Completing that sequence sets tuning bit and clears other status bits.
// RULE_09: Software loads clock staging then issues clock transfer and a write.
// RULE_10: Without tuning, software writes D2 into the trimming register.
// RULE_11: Tuning bit is cleared only after trimming has been written.
// RULE_12: Live clock and timer area is not directly addressable.
// RULE_13: Every data space location is readable and writable.
// RULE_14: Three status registers and one trimming register exist.
// RULE_15: Nine clock locations snapshot on read transfer and supply on write.
// RULE_16: Five directly written alarm locations exist.
// RULE_17: Four timer locations snapshot on read transfer and supply on write.
// RULE_18: Host settles address/data select before chip select and strobe.
// RULE_19: Two bus styles: separate strobes, or data strobe plus direction.
// RULE_20: Eight shared lines carry address and data in turn.
// RULE_21: Select low means address byte, high means data byte.
// RULE_22: Data accesses go to the last written address.
// RULE_23: Write after transfer command stores staging; read loads staging.
// RULE_24: Bus lines driven only while chip select and read are active.
// RULE_25: Write data captured when write strobe or chip select ends first.
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`default_nettype none
module rtcp_host_port #(
	parameter int CLOCK_WORDS = rtcp_pkg::CLOCK_WORDS,
	parameter int TIMER_WORDS = rtcp_pkg::TIMER_WORDS
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic rstn,
	// Power fail and bus style pins.
	input wire logic power_fail_n,
	input wire logic bus_style_ds,
	// Multiplexed host bus pins.
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic addr_data_sel,
	input wire logic [7:0] muxed_bus_lines_in,
	output logic [7:0] muxed_bus_lines_out,
	output logic muxed_bus_lines_oe,
	// Interrupt request, open drain.
	input wire logic alarm_event,
	input wire logic alarm_mask,
	output logic irq_n_oe,
	// Live keeping area.
	input wire logic [8*CLOCK_WORDS-1:0] live_clock,
	input wire logic [8*TIMER_WORDS-1:0] live_timer,
	output logic [8*CLOCK_WORDS-1:0] load_clock,
	output logic load_clock_stb,
	output logic [8*TIMER_WORDS-1:0] load_timer,
	output logic load_timer_stb,
	// Register contents for the keeping logic.
	output logic [7:0] status0,
	output logic [7:0] status1,
	output logic [7:0] status2,
	output logic [7:0] trim
);
	localparam int NSYNC = 14;
	logic [NSYNC-1:0] raw;
	logic [NSYNC-1:0] pin_q;
	logic [7:0] mem [0:255]; // RULE_06
	logic [7:0] addr_latch, next_addr_latch;
	logic init_armed, next_init_armed;
	logic rd_act, wr_act, prev_rd, prev_wr;
	logic next_prev_rd, next_prev_wr;
	logic standby;
	logic [7:0] rd_data;

	assign raw = {power_fail_n, bus_style_ds, cs_n, rd_n, wr_n, addr_data_sel,
		muxed_bus_lines_in};

	// Three-stage synchronisers; a bit changes once stages two and three agree.
	// Every stage resets high, the idle level of the strobes and of power fail,
	// so that no false strobe edge follows the release of reset.
	genvar g;
	generate
		for (g = 0; g < NSYNC; g++) begin : g_sync
			logic st1, st2, st3, held;
			logic next_held;
			always_comb begin
				next_held = (st2 == st3) ? st3 : held;
			end
			always_ff @(posedge mclk or negedge rstn) begin
				if (!rstn) begin
					st1 <= 1'b1;
					st2 <= 1'b1;
					st3 <= 1'b1;
					held <= 1'b1;
				end else begin
					st1 <= raw[g];
					st2 <= st1;
					st3 <= st2;
					held <= next_held;
				end
			end
			assign pin_q[g] = held;
		end
	endgenerate

	logic pf_q, style_q, cs_q, rd_q, wr_q, sel_q;
	logic [7:0] bus_q;
	assign pf_q = pin_q[13];
	assign style_q = pin_q[12];
	assign cs_q = pin_q[11];
	assign rd_q = pin_q[10];
	assign wr_q = pin_q[9];
	assign sel_q = pin_q[8];
	assign bus_q = pin_q[7:0];

	assign standby = !pf_q; // RULE_01
	// Style select: separate strobes, or data strobe with read/write direction.
	always_comb begin
		if (style_q) begin
			rd_act = !cs_q && !rd_q && wr_q; // RULE_19
			wr_act = !cs_q && !rd_q && !wr_q; // RULE_19
		end else begin
			rd_act = !cs_q && !rd_q; // RULE_19
			wr_act = !cs_q && !wr_q; // RULE_19
		end
	end

	function automatic logic in_space(input logic [7:0] a);
		in_space = (a <= rtcp_pkg::LOC_STATUS2) || (a == rtcp_pkg::LOC_TRIM)
			|| (a >= rtcp_pkg::LOC_CLOCK_FIRST && a <= rtcp_pkg::LOC_CLOCK_LAST)
			|| (a >= rtcp_pkg::LOC_ALARM_FIRST && a <= rtcp_pkg::LOC_ALARM_LAST) // RULE_16
			|| (a >= rtcp_pkg::LOC_TIMER_FIRST && a <= rtcp_pkg::LOC_TIMER_LAST);
	endfunction : in_space

	// Strobe edges after synchronisation; standby masks both of them.
	logic wr_end, rd_start;
	assign wr_end = prev_wr && !wr_act && !standby; // RULE_25
	assign rd_start = rd_act && !prev_rd && !standby;

	// A transfer command matches its own area, and the combined command both.
	function automatic logic is_cmd(input logic [7:0] a, input logic [7:0] c);
		is_cmd = (a == c) || (a == rtcp_pkg::CMD_BOTH_XFER);
	endfunction : is_cmd

	// Decode of the access that has just ended or begun.
	logic clk_cmd, tmr_cmd;
	logic addr_wr, data_wr, status2_wr, init_done, clk_fetch, tmr_fetch;
	always_comb begin
		clk_cmd = is_cmd(addr_latch, rtcp_pkg::CMD_CLOCK_XFER);
		tmr_cmd = is_cmd(addr_latch, rtcp_pkg::CMD_TIMER_XFER);
		addr_wr = wr_end && !sel_q; // RULE_21
		data_wr = wr_end && sel_q;
		status2_wr = data_wr && addr_latch == rtcp_pkg::LOC_STATUS2;
		init_done = status2_wr && init_armed && !bus_q[rtcp_pkg::INIT_BIT]; // RULE_08
		clk_fetch = rd_start && sel_q && clk_cmd; // RULE_15
		tmr_fetch = rd_start && sel_q && tmr_cmd; // RULE_17
	end

	// Address latch, initialisation arming and strobe history.
	always_comb begin
		next_addr_latch = addr_latch;
		next_init_armed = init_armed;
		next_prev_rd = rd_act && !standby;
		next_prev_wr = wr_act && !standby; // RULE_02
		if (addr_wr) begin
			next_addr_latch = bus_q; // RULE_21
		end
		if (status2_wr) begin
			next_init_armed = bus_q[rtcp_pkg::INIT_BIT]; // RULE_08
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			addr_latch <= 8'h00;
			init_armed <= 1'b0;
			prev_rd <= 1'b0;
			prev_wr <= 1'b0;
		end else begin
			addr_latch <= next_addr_latch; // RULE_22
			init_armed <= next_init_armed;
			prev_rd <= next_prev_rd;
			prev_wr <= next_prev_wr;
		end
	end

	// The data space has no reset: software must initialise it before use.
	always_ff @(posedge mclk) begin
		if (data_wr && in_space(addr_latch)) begin
			mem[addr_latch] <= bus_q; // RULE_13
		end
		if (init_done) begin
			mem[rtcp_pkg::LOC_STATUS0] <= rtcp_pkg::STATUS_AFTER_INIT; // RULE_08
			mem[rtcp_pkg::LOC_STATUS1] <= 8'h00; // RULE_08
			mem[rtcp_pkg::LOC_STATUS2] <= 8'h00; // RULE_08
		end
		for (int i = 0; i < CLOCK_WORDS; i++) begin
			if (clk_fetch) begin
				mem[8'(rtcp_pkg::LOC_CLOCK_FIRST + i)] <= live_clock[8*i +: 8]; // RULE_15
			end
		end
		for (int i = 0; i < TIMER_WORDS; i++) begin
			if (tmr_fetch) begin
				mem[8'(rtcp_pkg::LOC_TIMER_FIRST + i)] <= live_timer[8*i +: 8]; // RULE_17
			end
		end
	end

	always_comb begin
		if (!sel_q) begin
			rd_data = addr_latch;
		end else if (in_space(addr_latch)) begin
			rd_data = mem[addr_latch]; // RULE_12
		end else begin
			rd_data = 8'h00;
		end
	end

	logic [8*CLOCK_WORDS-1:0] next_load_clock;
	logic [8*TIMER_WORDS-1:0] next_load_timer;
	always_comb begin
		for (int i = 0; i < CLOCK_WORDS; i++) begin
			next_load_clock[8*i +: 8] = mem[8'(rtcp_pkg::LOC_CLOCK_FIRST + i)];
		end
		for (int i = 0; i < TIMER_WORDS; i++) begin
			next_load_timer[8*i +: 8] = mem[8'(rtcp_pkg::LOC_TIMER_FIRST + i)];
		end
	end

	// Next values of the registered outputs.
	logic [7:0] next_bus_out, next_status0, next_status1, next_status2, next_trim;
	logic next_bus_oe, next_irq_oe, next_clock_stb, next_timer_stb;
	always_comb begin
		next_bus_out = rd_data; // RULE_20
		next_bus_oe = rd_act && !standby; // RULE_24
		next_irq_oe = alarm_event && !alarm_mask; // RULE_05
		next_clock_stb = data_wr && clk_cmd; // RULE_23
		next_timer_stb = data_wr && tmr_cmd; // RULE_23
		next_status0 = mem[rtcp_pkg::LOC_STATUS0];
		next_status1 = mem[rtcp_pkg::LOC_STATUS1];
		next_status2 = mem[rtcp_pkg::LOC_STATUS2];
		next_trim = mem[rtcp_pkg::LOC_TRIM]; // RULE_14
	end

	// Bus drive and the interrupt pull-down; the alarm works in standby too.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			muxed_bus_lines_out <= 8'h00;
			muxed_bus_lines_oe <= 1'b0;
			irq_n_oe <= 1'b0;
		end else begin
			muxed_bus_lines_out <= next_bus_out;
			muxed_bus_lines_oe <= next_bus_oe;
			irq_n_oe <= next_irq_oe;
		end
	end

	// Staging contents and the one-cycle load strobes for the keeping logic.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			load_clock <= '0;
			load_timer <= '0;
			load_clock_stb <= 1'b0;
			load_timer_stb <= 1'b0;
		end else begin
			load_clock <= next_load_clock;
			load_timer <= next_load_timer;
			load_clock_stb <= next_clock_stb;
			load_timer_stb <= next_timer_stb;
		end
	end

	// Register copies for the keeping logic.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			status0 <= 8'h00;
			status1 <= 8'h00;
			status2 <= 8'h00;
			trim <= 8'h00;
		end else begin
			status0 <= next_status0;
			status1 <= next_status1;
			status2 <= next_status2;
			trim <= next_trim;
		end
	end
endmodule : rtcp_host_port
`default_nettype wire

// >>> src/rtcp_pkg.sv
// Purpose: Shared constants for the real-time clock host port and data space.
// Assumes: One clock, mclk at 100 MHz.
// Notes: Locations are byte addresses on the multiplexed bus.
`default_nettype none
package rtcp_pkg;
	localparam logic [7:0] LOC_STATUS0 = 8'h00;
	localparam logic [7:0] LOC_STATUS1 = 8'h01;
	localparam logic [7:0] LOC_STATUS2 = 8'h02;
	localparam logic [7:0] LOC_TRIM = 8'h10;
	localparam logic [7:0] LOC_CLOCK_FIRST = 8'h20;
	localparam logic [7:0] LOC_CLOCK_LAST = 8'h28;
	localparam logic [7:0] LOC_ALARM_FIRST = 8'h30;
	localparam logic [7:0] LOC_ALARM_LAST = 8'h34;
	localparam logic [7:0] LOC_TIMER_FIRST = 8'h40;
	localparam logic [7:0] LOC_TIMER_LAST = 8'h43;
	localparam logic [7:0] CMD_BOTH_XFER = 8'hF0;
	localparam logic [7:0] CMD_CLOCK_XFER = 8'hF1;
	localparam logic [7:0] CMD_TIMER_XFER = 8'hF2;
	localparam int INIT_BIT = 4;
	localparam int TUNE_BIT = 0;
	localparam logic [7:0] STATUS_AFTER_INIT = 8'h01;
	localparam int CLOCK_WORDS = 9;
	localparam int TIMER_WORDS = 4;
	localparam int ALARM_WORDS = 5;
endpackage : rtcp_pkg
`default_nettype wire

// >>> tb/rtcp_host_model.sv
// Purpose: Processor model on the multiplexed bus.
// Assumes: Every pin but the bus lines is held six cycles or more; a released bus value can last one cycle.
// Notes: Released lines show the inverse of the last access's data byte, so all ones after a read.
`default_nettype none
module rtcp_host_model (
	// Clock and bus style.
	input wire logic mclk,
	input wire logic style,
	// Bus pins.
	input wire logic [7:0] bus_in,
	output logic cs_n,
	output logic rd_n,
	output logic wr_n,
	output logic sel,
	output logic [7:0] bus_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] drv = 8'h00;
	logic drv_on = 1'b0;
	assign bus_out = drv_on ? drv : ~drv;
	initial begin
		cs_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		sel = 1'b0;
	end
	task automatic access(input logic w, input logic a_d, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge mclk);
		sel <= a_d;
		drv <= d;
		drv_on <= w;
		wr_n <= !(style && w);
		repeat (6) @(posedge mclk);
		cs_n <= 1'b0;
		if (w && !style) wr_n <= 1'b0;
		else rd_n <= 1'b0;
		repeat (9) @(posedge mclk);
		q = bus_in;
		cs_n <= 1'b1;
		rd_n <= 1'b1;
		wr_n <= 1'b1;
		repeat (8) @(posedge mclk);
		drv_on <= 1'b0;
	endtask : access
endmodule : rtcp_host_model
`default_nettype wire

// >>> tb/rtcp_host_port_assertions.sv
// Purpose: Port checks for the host port.
// Assumes: Pins reach the logic after about four cycles of sync delay.
// Notes: Bound into every rtcp_host_port instance.
`default_nettype none
module rtcp_host_port_chk (
	// Clock and reset.
	input wire logic mclk,
	input wire logic rstn,
	// Pins.
	input wire logic power_fail_n,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic alarm_event,
	input wire logic alarm_mask,
	// Outputs.
	input wire logic muxed_bus_lines_oe,
	input wire logic irq_n_oe,
	input wire logic load_clock_stb,
	input wire logic load_timer_stb
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] idle;
	logic [4:0] next_idle;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	// Counts cycles since chip select last went away, saturating.
	always_comb next_idle = !cs_n ? 5'h00 : (idle == 5'h1F) ? idle : idle + 5'h01;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) idle <= 5'h00;
		else idle <= next_idle;
	end
	property p_standby_quiet; !power_fail_n [*8] |-> !muxed_bus_lines_oe; endproperty
	a_standby_quiet: assert property (p_standby_quiet) else $error("bus driven in standby");
	property p_standby_load; !power_fail_n [*8] |-> !load_clock_stb && !load_timer_stb; endproperty
	a_standby_load: assert property (p_standby_load) else $error("load in standby");
	property p_idle_quiet; idle > 5'h0C |-> !muxed_bus_lines_oe && !load_clock_stb; endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("activity while idle");
	property p_read_drives; (!cs_n && !rd_n && wr_n && power_fail_n) [*8] |-> muxed_bus_lines_oe;
	endproperty
	a_read_drives: assert property (p_read_drives) else $error("read not driven");
	property p_irq_on; (alarm_event && !alarm_mask) [*8] |-> irq_n_oe; endproperty
	a_irq_on: assert property (p_irq_on) else $error("irq not pulled");
	property p_irq_mask; alarm_mask [*8] |-> !irq_n_oe; endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("masked irq pulled");
	property p_clk_pulse; load_clock_stb |=> !load_clock_stb; endproperty
	a_clk_pulse: assert property (p_clk_pulse) else $error("clock load too long");
	property p_tmr_pulse; load_timer_stb |=> !load_timer_stb; endproperty
	a_tmr_pulse: assert property (p_tmr_pulse) else $error("timer load too long");
endmodule : rtcp_host_port_chk
bind rtcp_host_port rtcp_host_port_chk rtcp_host_port_chk_inst (.mclk(mclk), .rstn(rstn),
	.power_fail_n(power_fail_n), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
	.alarm_event(alarm_event), .alarm_mask(alarm_mask), .muxed_bus_lines_oe(muxed_bus_lines_oe),
	.irq_n_oe(irq_n_oe), .load_clock_stb(load_clock_stb), .load_timer_stb(load_timer_stb));
`default_nettype wire

// >>> tb/tb_rtcp_host_port.sv
// Purpose: Self-checking bench for the host port.
// Assumes: Fixed live clock and timer values.
// Notes: Expected bytes follow from the values written.
`default_nettype none
module tb_rtcp_host_port;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, rstn = 1'b0, power_fail_n = 1'b0, style = 1'b0, alarm_event = 1'b0, alarm_mask = 1'b0;
	logic cs_n, rd_n, wr_n, sel, oe, irq, cstb, tstb;
	logic [7:0] hbus, dout, s0, s1, s2, trim;
	logic [71:0] lclk;
	logic [31:0] ltmr;
	wire logic [7:0] bus = oe ? dout : hbus;
	int err_total = 0, checks = 0, cp = 0, tp = 0, i, n;
	rtcp_host_model rtcp_host_model_inst (.mclk(mclk), .style(style), .bus_in(bus), .cs_n(cs_n),
		.rd_n(rd_n), .wr_n(wr_n), .sel(sel), .bus_out(hbus));
	rtcp_host_port rtcp_host_port_inst (.mclk(mclk), .rstn(rstn), .power_fail_n(power_fail_n),
		.bus_style_ds(style), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr_data_sel(sel),
		.muxed_bus_lines_in(bus), .muxed_bus_lines_out(dout), .muxed_bus_lines_oe(oe),
		.alarm_event(alarm_event), .alarm_mask(alarm_mask), .irq_n_oe(irq),
		.live_clock(72'h090807060504030201), .live_timer(32'hA4A3A2A1), .load_clock(lclk),
		.load_clock_stb(cstb), .load_timer(ltmr), .load_timer_stb(tstb), .status0(s0),
		.status1(s1), .status2(s2), .trim(trim));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		if (cstb === 1'b1) cp++;
		if (tstb === 1'b1) tp++;
	end
	task automatic cmp(input string nm, input logic [71:0] exp, input logic [71:0] got);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s exp %h got %h", nm, exp, got);
		end
	endtask : cmp
	task automatic wr(input logic a_d, input logic [7:0] d);
		logic [7:0] q;
		rtcp_host_model_inst.access(1'b1, a_d, d, q);
	endtask : wr
	task automatic rd(input string nm, input logic a_d, input logic [7:0] exp);
		logic [7:0] q;
		rtcp_host_model_inst.access(1'b0, a_d, 8'h00, q);
		cmp(nm, {64'h0, exp}, {64'h0, q});
	endtask : rd
	task automatic loc(input logic [7:0] a, input logic [7:0] d);
		wr(1'b0, a);
		wr(1'b1, d);
	endtask : loc
	task automatic chk(input string nm, input logic [7:0] a, input logic [7:0] exp);
		wr(1'b0, a);
		rd(nm, 1'b1, exp);
	endtask : chk
	task automatic tally_and_finish();
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (20000) @(posedge mclk);
		err_total++;
		tally_and_finish();
	end
	initial begin
		repeat (10) @(posedge mclk);
		rstn <= 1'b1;
		power_fail_n <= 1'b1;
		repeat (8) @(posedge mclk);
		loc(rtcp_pkg::LOC_STATUS2, 8'h10);
		wr(1'b1, 8'h00);
		for (i = 0; i < 3; i++) chk("status", 8'(i), i == 0 ? 8'h01 : 8'h00);
		cmp("status0_out", 72'(rtcp_pkg::STATUS_AFTER_INIT), 72'(s0));
		cmp("status1_out", 72'h0, 72'(s1));
		cmp("status2_out", 72'h0, 72'(s2));
		loc(rtcp_pkg::LOC_TRIM, 8'hD2);
		chk("trim", rtcp_pkg::LOC_TRIM, 8'hD2);
		cmp("trim_out", 72'hD2, 72'(trim));
		loc(rtcp_pkg::LOC_STATUS0, 8'h00);
		chk("status0", rtcp_pkg::LOC_STATUS0, 8'h00);
		for (i = 0; i < 9; i++) loc(8'h20 + 8'(i), 8'h30 + 8'(i));
		n = cp;
		loc(rtcp_pkg::CMD_CLOCK_XFER, 8'h00);
		cmp("clock_pulses", 72'(n + 1), 72'(cp));
		cmp("load_clock", 72'h383736353433323130, lclk);
		wr(1'b0, rtcp_pkg::CMD_BOTH_XFER);
		rd("xfer", 1'b1, 8'h00);
		chk("clk_first", 8'h20, 8'h01);
		chk("clk_last", 8'h28, 8'h09);
		chk("tmr_last", 8'h43, 8'hA4);
		n = tp;
		loc(rtcp_pkg::CMD_TIMER_XFER, 8'h00);
		cmp("timer_pulses", 72'(n + 1), 72'(tp));
		cmp("load_timer", 72'hA4A3A2A1, 72'(ltmr));
		for (i = 0; i < 5; i++) loc(8'h30 + 8'(i), 8'h50 + 8'(i));
		for (i = 0; i < 5; i++) chk("alarm", 8'h30 + 8'(i), 8'h50 + 8'(i));
		rd("latch", 1'b0, 8'h34);
		rd("same_loc", 1'b1, 8'h54);
		chk("hidden", 8'h60, 8'h00);
		power_fail_n <= 1'b0;
		alarm_event <= 1'b1;
		repeat (10) @(posedge mclk);
		cmp("irq", 72'h1, 72'(irq));
		alarm_mask <= 1'b1;
		loc(8'h30, 8'hEE);
		cmp("irq_masked", 72'h0, 72'(irq));
		power_fail_n <= 1'b1;
		repeat (8) @(posedge mclk);
		chk("standby_write", 8'h30, 8'h50);
		style <= 1'b1;
		loc(8'h31, 8'h77);
		chk("ds_style", 8'h31, 8'h77);
		tally_and_finish();
	end
endmodule : tb_rtcp_host_port
`default_nettype wire
